/* File: wdt_defs.svh */
`ifndef WDT_DEFS_SVH
`define WDT_DEFS_SVH

// --------------------
// Register indices (byte address = 4 x index)
// --------------------
`define WDT_IDX_SELECT      10'h009
`define WDT_IDX_STATUS      10'h00A
`define WDT_IDX_CMD         10'h010
`define WDT_IDX_STATE       10'h011

// --------------------
// Reset values
// --------------------
`define WDT_SELECT_RST      8'h07

// --------------------
// Field positions
// --------------------
`define WDT_SEL_RATIO_LSB   0
`define WDT_SEL_RATIO_MSB   2
`define WDT_SEL_RSVD_BIT    3
`define WDT_SEL_TEST_LSB    4
`define WDT_SEL_TEST_MSB    7
`define WDT_TEST_DAC_CODE   4'h5
`define WDT_STAT_SLEEP_BIT  4
`define WDT_STAT_EXPIRY_BIT 5
`define WDT_CMD_CLR_BIT     0
`define WDT_CMD_CLR1_BIT    1
`define WDT_CMD_CLR2_BIT    2
`define WDT_CMD_HALT_BIT    3

// --------------------
// Timing counts
// --------------------
`define WDT_BASE_BITS       8
`define WDT_INSTR_DIV       4
`define WDT_DUMMY_CYCLES    1024

`endif

/* File: wdt_pkg.sv */
package wdt_pkg;

    // --------------------
    // Power state of the core
    // --------------------
    typedef enum logic [1:0] {
        S_RUN   = 2'b00,    // Executing
        S_HALT  = 2'b01,    // Oscillator stopped
        S_DUMMY = 2'b10     // Start-up wait after wake or reset
    } pwr_state_t;

    // Why the dummy period was entered
    typedef enum logic [1:0] {
        W_NEXT  = 2'b00,    // Resume at next instruction
        W_IRQ   = 2'b01,    // Take interrupt response
        W_RESET = 2'b10     // Restart from reset vector
    } wake_kind_t;

    // Status flags seen by software
    typedef struct packed {
        logic expiry_flag;
        logic sleep_flag;
    } status_t;

    // One-cycle requests toward the processor core
    typedef struct packed {
        logic chip_reset;   // Full reset
        logic warm_reset;   // Program counter and stack pointer only
        logic resume_next;  // Continue after the halt
        logic resume_irq;   // Enter interrupt response
    } cpu_ctl_t;

endpackage : wdt_pkg

/* File: wdt_counter.sv */
module wdt_counter #(
    parameter int unsigned BASE_BITS  = 8,
    parameter int unsigned RATIO_BITS = 3
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clear,
    input  wire logic                  tick,
    input  wire logic [RATIO_BITS-1:0] ratio,
    output logic                       overflow
);
    import wdt_pkg::*;

    // --------------------
    // Divider and prescaler chained as one counter
    // --------------------
    localparam int unsigned CW = BASE_BITS + (1 << RATIO_BITS) - 1;

    logic [CW-1:0] count_ff;     // Ticks since last clear or overflow
    logic [CW-1:0] nxt_count;    // Next count
    logic          overflow_ff;  // Registered overflow pulse
    logic          at_last;      // Count reached selected terminal

    // Last count before overflow for a given ratio
    function automatic logic [CW-1:0] last_count(
        input logic [RATIO_BITS-1:0] r
    );
        last_count = CW'((32'd1 << (BASE_BITS + 32'(r))) - 32'd1);
    endfunction : last_count

    // Greater-or-equal so a ratio lowered mid-count still fires
    assign at_last  = count_ff >= last_count(ratio);
    assign overflow = overflow_ff;

    // Next count: clear has priority over counting
    always_comb begin
        if (clear) begin
            nxt_count = '0;
        end else if (tick) begin
            nxt_count = at_last ? '0 : count_ff + 1'b1;
        end else begin
            nxt_count = count_ff;
        end
    end

    // Counter and overflow flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff    <= '0;
            overflow_ff <= 1'b0;
        end else begin
            count_ff    <= nxt_count;
            overflow_ff <= !clear && tick && at_last;
        end
    end

endmodule : wdt_counter

/* File: wdt_power_ctl.sv */
// Our own choice: the APB interface to the registers.
`include "wdt_defs.svh"
// Behaviour
// [RULE_01] Clock from RC oscillator or instruction clock
// [RULE_02] Divide selected clock by 256 first
// [RULE_03] Prescale by two to the ratio field
// [RULE_04] Select register bit 3 reads zero
// [RULE_05] Upper nibble 0101 enters DAC test
// [RULE_06] Disabled watchdog makes related actions no-ops
// [RULE_07] Instruction-clock source stops counting in halt
// [RULE_08] Normal overflow: chip reset, set expiry flag
// [RULE_09] Halt overflow: warm reset of PC, SP
// [RULE_10] Reset pin, clear, halt clear the count
// [RULE_11] Single or dual clear instruction option
// [RULE_12] Halt stops system oscillator, RC keeps running
// [RULE_13] Halt preserves RAM, registers, port states
// [RULE_14] Halt clears counter and prescaler on RC
// [RULE_15] Halt sets sleep flag, clears expiry flag
// [RULE_16] Power-up and clear instruction clear sleep
// [RULE_17] Wake on reset, interrupt, port, overflow
// [RULE_18] Per-bit port wake mask, resume next
// [RULE_19] Interrupt wake: response if enabled, room
// [RULE_20] Pending-before-halt interrupt cannot wake
// [RULE_21] 1024-cycle dummy period after any wake
// [RULE_22] RC oscillator optional, runs during halt
// [RULE_23] Overflow after 256 times ratio ticks
module wdt_power_ctl #(
    parameter bit          WDT_ENABLE    = 1'b1,
    parameter bit          SRC_RC        = 1'b1,
    parameter bit          DUAL_CLEAR    = 1'b0,
    parameter bit          RC_OSC_ENABLE = 1'b1,
    parameter logic [7:0]  PA_WAKE_MASK  = 8'hFF,
    parameter int unsigned N_IRQ         = 3
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  ext_rst_n,
    input  wire logic                  rc_osc_in,
    input  wire logic [7:0]            port_a_in,
    input  wire logic [N_IRQ-1:0]      irq_req,
    input  wire logic [N_IRQ-1:0]      irq_en,
    input  wire logic                  irq_master_en,
    input  wire logic                  stack_full,
    output wdt_pkg::cpu_ctl_t          cpu_ctl,
    output wdt_pkg::status_t           status,
    output logic                       cpu_halted,
    output logic                       sys_osc_run,
    output logic                       rc_osc_en,
    output logic                       dac_test_mode
);
    import wdt_pkg::*;

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam logic [9:0] DUMMY_LAST = 10'(`WDT_DUMMY_CYCLES - 1);
    localparam logic [1:0] DIV_LAST   = 2'(`WDT_INSTR_DIV - 1);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic             rc_meta_ff;     // Oscillator pin, first stage
    logic             rc_sync_ff;     // Oscillator pin, second stage
    logic             rc_prev_ff;     // Delayed copy for edge detect
    logic             rst_meta_ff;    // Reset pin, first stage
    logic             rst_sync_ff;    // Reset pin, second stage
    logic [7:0]       pa_meta_ff;     // Port A, first stage
    logic [7:0]       pa_sync_ff;     // Port A, second stage
    logic [7:0]       pa_prev_ff;     // Port A, delayed copy
    pwr_state_t       state_ff;       // Power state
    pwr_state_t       nxt_state;
    wake_kind_t       kind_ff;        // Cause of current dummy period
    wake_kind_t       nxt_kind;
    logic [9:0]       dummy_ff;       // Dummy period counter
    logic [9:0]       nxt_dummy;
    logic [1:0]       div_ff;         // Instruction clock divider
    logic [7:0]       select_ff;      // Watchdog select register
    logic [7:0]       nxt_select;
    status_t          status_ff;      // Sleep and expiry flags
    status_t          nxt_status;
    logic             clr1_seen_ff;   // First dual clear executed
    logic             clr2_seen_ff;   // Second dual clear executed
    logic [N_IRQ-1:0] irq_held_ff;    // Requests pending at halt
    cpu_ctl_t         ctl_ff;         // Core requests
    cpu_ctl_t         nxt_ctl;
    logic             osc_run_ff;     // System oscillator enable
    logic [31:0]      prdata_ff;      // Registered read data

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    // Byte address of a register index
    function automatic logic reg_hit(
        input logic [11:0] addr,
        input logic [9:0]  idx
    );
        reg_hit = (addr == {idx, 2'b00});
    endfunction : reg_hit

    wire hit_select = reg_hit(paddr, `WDT_IDX_SELECT);
    wire hit_status = reg_hit(paddr, `WDT_IDX_STATUS);
    wire hit_cmd    = reg_hit(paddr, `WDT_IDX_CMD);
    wire hit_state  = reg_hit(paddr, `WDT_IDX_STATE);
    wire hit_any    = hit_select | hit_status | hit_cmd | hit_state;
    wire setup_ph   = psel & ~penable;
    wire wr_access  = psel & penable & pwrite & hit_any;
    wire running    = (state_ff == S_RUN);
    wire halted     = (state_ff == S_HALT);

    // Commands only execute while the core runs
    wire cmd_wr     = wr_access & hit_cmd & running;
    wire cmd_clr    = cmd_wr & pwdata[`WDT_CMD_CLR_BIT];
    wire cmd_clr1   = cmd_wr & pwdata[`WDT_CMD_CLR1_BIT];
    wire cmd_clr2   = cmd_wr & pwdata[`WDT_CMD_CLR2_BIT];
    wire cmd_halt   = cmd_wr & pwdata[`WDT_CMD_HALT_BIT];

    // ------------------------------------------------------------------
    // Clear instruction option
    // ------------------------------------------------------------------
    // Dual mode needs both halves in any order
    wire clr1_done  = clr1_seen_ff | cmd_clr1;
    wire clr2_done  = clr2_seen_ff | cmd_clr2;
    wire clr_exec   = WDT_ENABLE &&
                      (DUAL_CLEAR ? (clr1_done & clr2_done)
                                  : cmd_clr);                 // [RULE_11]

    // ------------------------------------------------------------------
    // Watchdog clock source
    // ------------------------------------------------------------------
    wire rc_tick    = RC_OSC_ENABLE & rc_sync_ff & ~rc_prev_ff; // [RULE_22]
    // Instruction clock dies with the oscillator in halt
    wire instr_tick = (div_ff == DIV_LAST) & ~halted;         // [RULE_07]
    wire wdt_tick   = WDT_ENABLE &&
                      (SRC_RC ? rc_tick : instr_tick);        // [RULE_01]
    wire ext_rst    = ~rst_sync_ff;

    // Disabled watchdog holds its count at zero
    wire wdt_clear  = ext_rst | clr_exec | cmd_halt |
                      !WDT_ENABLE;                    // [RULE_10] [RULE_06]
    logic wdt_ovf;

    // Divide-by-256 then prescaler; halt clear resets both stages
    wdt_counter #(
        .BASE_BITS  (`WDT_BASE_BITS),
        .RATIO_BITS (3)
    ) u_counter (
        .pclk     (pclk),
        .presetn  (presetn),
        .clear    (wdt_clear),                                // [RULE_14]
        .tick     (wdt_tick),
        .ratio    (select_ff[`WDT_SEL_RATIO_MSB:`WDT_SEL_RATIO_LSB]),
        .overflow (wdt_ovf)               // [RULE_02] [RULE_03] [RULE_23]
    );

    // ------------------------------------------------------------------
    // Wake sources
    // ------------------------------------------------------------------
    wire [7:0] pa_fall = pa_prev_ff & ~pa_sync_ff;
    wire port_wake     = |(pa_fall & PA_WAKE_MASK);           // [RULE_18]
    // Only requests raised after the halt may wake
    wire [N_IRQ-1:0] irq_new = irq_req & ~irq_held_ff;        // [RULE_20]
    wire irq_wake      = |irq_new;
    wire irq_take      = irq_master_en & |(irq_new & irq_en) &
                         ~stack_full;                         // [RULE_19]

    // ------------------------------------------------------------------
    // Power state machine
    // ------------------------------------------------------------------
    // Reset pin beats overflow, which beats interrupt and port
    always_comb begin
        nxt_state = state_ff;
        nxt_kind  = kind_ff;
        nxt_dummy = dummy_ff;
        nxt_ctl   = '0;
        case (state_ff)
            S_RUN: begin
                if (ext_rst) begin
                    nxt_state = S_DUMMY;
                    nxt_kind  = W_RESET;
                    nxt_dummy = '0;
                end else if (wdt_ovf) begin
                    nxt_state          = S_DUMMY;
                    nxt_kind           = W_RESET;
                    nxt_dummy          = '0;
                    nxt_ctl.chip_reset = 1'b1;                // [RULE_08]
                end else if (cmd_halt) begin
                    nxt_state = S_HALT;                       // [RULE_12]
                end
            end
            S_HALT: begin
                nxt_dummy = '0;
                if (ext_rst) begin
                    nxt_state = S_DUMMY;
                    nxt_kind  = W_RESET;
                end else if (wdt_ovf) begin
                    nxt_state          = S_DUMMY;
                    nxt_kind           = W_RESET;
                    nxt_ctl.warm_reset = 1'b1;                // [RULE_09]
                end else if (irq_wake) begin
                    nxt_state = S_DUMMY;
                    nxt_kind  = irq_take ? W_IRQ : W_NEXT;    // [RULE_19]
                end else if (port_wake) begin
                    nxt_state = S_DUMMY;
                    nxt_kind  = W_NEXT;                       // [RULE_17]
                end
            end
            S_DUMMY: begin
                if (ext_rst) begin
                    // Pin held low keeps the wait from starting
                    nxt_dummy = '0;
                    nxt_kind  = W_RESET;
                end else if (wdt_ovf) begin
                    nxt_dummy          = '0;
                    nxt_kind           = W_RESET;
                    nxt_ctl.chip_reset = 1'b1;
                end else if (dummy_ff == DUMMY_LAST) begin
                    // Execution continues right after the wait
                    nxt_state           = S_RUN;              // [RULE_21]
                    nxt_ctl.resume_irq  = (kind_ff == W_IRQ);
                    nxt_ctl.resume_next = (kind_ff != W_IRQ);
                end else begin
                    nxt_dummy = dummy_ff + 10'd1;             // [RULE_21]
                end
            end
            default: begin
                nxt_state = S_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Status flags and select register
    // ------------------------------------------------------------------
    // Overflow is applied last so it wins over any clear
    always_comb begin
        nxt_status = status_ff;
        nxt_select = select_ff;
        if (wr_access && hit_select) begin
            nxt_select = {pwdata[7:4], 1'b0, pwdata[2:0]};    // [RULE_04]
        end
        if (clr_exec) begin
            nxt_status.sleep_flag  = 1'b0;                    // [RULE_16]
            nxt_status.expiry_flag = 1'b0;
        end
        if (cmd_halt) begin
            nxt_status.sleep_flag  = 1'b1;                    // [RULE_15]
            nxt_status.expiry_flag = 1'b0;
        end
        if (ext_rst) begin
            nxt_select = `WDT_SELECT_RST;
        end
        if (wdt_ovf) begin
            nxt_status.expiry_flag = 1'b1;                    // [RULE_08]
            // Warm reset in halt keeps the select register
            if (!halted) begin
                nxt_select = `WDT_SELECT_RST;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    wire [31:0] rd_select = {24'h00_0000, select_ff};         // [RULE_04]
    wire [31:0] rd_status = {26'h000_0000, status_ff.expiry_flag,
                             status_ff.sleep_flag, 4'h0};
    wire [31:0] rd_state  = {27'h000_0000, dac_test_mode,
                             kind_ff, state_ff};
    wire [31:0] rd_data   = hit_select ? rd_select :
                            hit_status ? rd_status :
                            hit_state  ? rd_state  : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    // Pins pass two flops before any logic reads them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_meta_ff  <= 1'b0;
            rc_sync_ff  <= 1'b0;
            rc_prev_ff  <= 1'b0;
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= 1'b1;
            pa_meta_ff  <= 8'hFF;
            pa_sync_ff  <= 8'hFF;
            pa_prev_ff  <= 8'hFF;
        end else begin
            rc_meta_ff  <= rc_osc_in;
            rc_sync_ff  <= rc_meta_ff;
            rc_prev_ff  <= rc_sync_ff;
            rst_meta_ff <= ext_rst_n;
            rst_sync_ff <= rst_meta_ff;
            pa_meta_ff  <= port_a_in;
            pa_sync_ff  <= pa_meta_ff;
            pa_prev_ff  <= pa_sync_ff;
        end
    end

    // ------------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------------
    // Power-up clears both flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= S_RUN;
            kind_ff   <= W_NEXT;
            dummy_ff  <= '0;
            ctl_ff    <= '0;
            status_ff <= '0;                                  // [RULE_16]
            select_ff <= `WDT_SELECT_RST;
        end else begin
            state_ff  <= nxt_state;
            kind_ff   <= nxt_kind;
            dummy_ff  <= nxt_dummy;
            ctl_ff    <= nxt_ctl;
            status_ff <= nxt_status;
            select_ff <= nxt_select;
        end
    end

    // Oscillator gate and instruction clock divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_run_ff <= 1'b1;
            div_ff     <= '0;
        end else begin
            osc_run_ff <= (nxt_state != S_HALT);              // [RULE_12]
            div_ff     <= halted ? div_ff : div_ff + 2'd1;
        end
    end

    // Dual clear halves and requests pending at halt entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr1_seen_ff <= 1'b0;
            clr2_seen_ff <= 1'b0;
            irq_held_ff  <= '0;
        end else begin
            clr1_seen_ff <= clr1_done & ~clr_exec & ~ext_rst;
            clr2_seen_ff <= clr2_done & ~clr_exec & ~ext_rst;
            if (cmd_halt) begin
                irq_held_ff <= irq_req;                       // [RULE_20]
            end
        end
    end

    // Read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata_ff <= rd_data;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Nothing here touches core state during halt; it simply stays put
    assign cpu_halted    = halted;                            // [RULE_13]
    assign cpu_ctl       = ctl_ff;
    assign status        = status_ff;
    assign sys_osc_run   = osc_run_ff;
    assign rc_osc_en     = RC_OSC_ENABLE;                     // [RULE_22]
    assign dac_test_mode = (select_ff[`WDT_SEL_TEST_MSB:`WDT_SEL_TEST_LSB]
                            == `WDT_TEST_DAC_CODE);           // [RULE_05]
    assign prdata        = prdata_ff;
    assign pready        = 1'b1;
    assign pslverr       = psel & penable & ~hit_any;

endmodule : wdt_power_ctl

/* File: wdt_power_ctl_assertions.sv */
module wdt_power_ctl_assertions (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    input wire wdt_pkg::cpu_ctl_t cpu_ctl,
    input wire wdt_pkg::status_t  status,
    input wire logic              cpu_halted,
    input wire logic              sys_osc_run,
    input wire logic              dac_test_mode
);
    import wdt_pkg::*;
    // --------------------
    // Watchdog and halt checks, all in the pclk domain
    // --------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Access phase on the select word
    sequence sel_wr_s;
        psel && penable && pwrite && paddr == 12'h024;
    endsequence
    sequence sel_rd_s;
        psel && penable && !pwrite && paddr == 12'h024;
    endsequence
    logic [10:0] wake_n;  // Cycles since leaving halt, 0 when idle
    // A core request stops the count unless it comes as halt ends; a long wait is too many cycles
    // for a delay range, so it is counted here instead
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) wake_n <= '0;
        else if ($fell(cpu_halted)) wake_n <= 11'd1;
        else if (cpu_ctl != '0 || wake_n == '0) wake_n <= '0;
        else wake_n <= wake_n + 11'd1;
    end
    dac_decode_a: assert property (sel_wr_s |=>
        dac_test_mode == ($past(pwdata[7:4]) == 4'h5))
        else $error("Test mode decode wrong");
    rsvd_bit_a: assert property (sel_rd_s |->
        !prdata[3] && prdata[31:8] == 24'h00_0000)
        else $error("Reserved select bit not zero");
    unmapped_a: assert property (psel && penable && paddr == 12'h0FC |->
        pslverr) else $error("Unmapped access not refused");
    halt_flags_a: assert property ($rose(cpu_halted) |->
        status == 2'b01) else $error("Halt flags wrong");
    osc_off_a: assert property (cpu_halted |-> !sys_osc_run)
        else $error("Oscillator runs in halt");
    expiry_set_a: assert property (cpu_ctl.chip_reset |->
        ##[0:1] status.expiry_flag) else $error("Expiry flag not set");
    warm_flags_a: assert property (cpu_ctl.warm_reset |->
        ##[0:1] status == 2'b11) else $error("Warm reset flags wrong");
    dummy_len_a: assert property ((cpu_ctl.resume_next ||
        cpu_ctl.resume_irq) && wake_n != '0 |-> wake_n == 11'd1024)
        else $error("Start-up wait length wrong");
    ctl_pulse_a: assert property ($onehot0(cpu_ctl))
        else $error("Core requests overlap");
endmodule : wdt_power_ctl_assertions

bind wdt_power_ctl wdt_power_ctl_assertions i_wdt_power_ctl_assertions (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pslverr(pslverr), .cpu_ctl(cpu_ctl), .status(status),
    .cpu_halted(cpu_halted), .sys_osc_run(sys_osc_run),
    .dac_test_mode(dac_test_mode));

/* File: watchdog_and_power_down_bench.sv */
module watchdog_and_power_down_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import wdt_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, pready, pslverr, err, cpu_halted;
    logic        sys_osc_run, rc_osc_en, dac_test_mode;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic [7:0]  port_a_in = 8'hFF;
    logic [2:0]  irq_req = 3'h0;
    logic [1:0]  rc_div = 2'h0;  // RC pin at a quarter of pclk
    cpu_ctl_t    cpu_ctl;
    status_t     status;
    int          mismatches = 0, n_tests = 0, n;
    // Test-mode bit, select write, expected readback
    logic [16:0] rows [4] = '{17'h1_5F57, 17'h0_FFF7, 17'h0_4840, 17'h1_5050};
    always #4 pclk = ~pclk;
    always @(posedge pclk) rc_div <= rc_div + 2'h1;
    wdt_power_ctl i_wdt_power_ctl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_rst_n(1'b1),
        .rc_osc_in(rc_div[1]), .port_a_in(port_a_in), .irq_req(irq_req),
        .irq_en(3'h7), .irq_master_en(1'b1), .stack_full(1'b0),
        .cpu_ctl(cpu_ctl), .status(status), .cpu_halted(cpu_halted),
        .sys_osc_run(sys_osc_run), .rc_osc_en(rc_osc_en),
        .dac_test_mode(dac_test_mode));
    // --------------------
    // Compare, bus transfer and bounded waits
    // --------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic rng(input int lo, input int hi);
        chk(32'(n >= lo && n <= hi), 32'h0000_0001);
    endtask : rng
    // Setup, then access until pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            mismatches++;
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // Wait for a core request pulse; n counts cycles
    task automatic wait_ctl(input int b);
        n = 0;
        while (cpu_ctl[b] !== 1'b1 && n < 3000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 3000) begin
            mismatches++;
            give_verdict();
        end
    endtask : wait_ctl
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(rc_osc_en, 32'h0000_0001);
        apb(0, 12'h024, 8'h00);
        chk(rd, 32'h0000_0007);
        apb(0, 12'h028, 8'h00);
        chk(rd, 32'h0000_0000);
        foreach (rows[i]) begin
            apb(1, 12'h024, rows[i][15:8]);
            apb(0, 12'h024, 8'h00);
            chk(rd, {24'h00_0000, rows[i][7:0]});
            chk(dac_test_mode, rows[i][16]);
        end
        apb(0, 12'h0FC, 8'h00);
        chk({err, rd[30:0]}, 32'h8000_0000); // Unmapped word refused
        // Ratio 1:1, kept alive by clears, then let it expire
        apb(1, 12'h024, 8'h00);
        repeat (5) begin
            repeat (600) @(posedge pclk);
            apb(1, 12'h040, 8'h01);
        end
        wait_ctl(3);
        rng(1010, 1040);
        wait_ctl(1);
        rng(1015, 1035);
        apb(0, 12'h028, 8'h00);
        chk(rd, 32'h0000_0020);
        // Halt, then a port A fall wakes
        apb(1, 12'h040, 8'h08);
        chk({cpu_halted, sys_osc_run}, 32'h0000_0002);
        port_a_in <= 8'hFE;
        wait_ctl(1);
        rng(1020, 1040);
        port_a_in <= 8'hFF;
        apb(0, 12'h028, 8'h00);
        chk(rd, 32'h0000_0010);
        apb(1, 12'h040, 8'h01);
        apb(0, 12'h028, 8'h00);
        chk(rd, 32'h0000_0000);
        // Overflow during halt gives a warm reset
        apb(1, 12'h024, 8'h01);
        apb(1, 12'h040, 8'h08);
        wait_ctl(2);
        rng(2035, 2065);
        wait_ctl(1);
        apb(0, 12'h028, 8'h00);
        chk(rd, 32'h0000_0030);
        apb(1, 12'h024, 8'h07);
        apb(1, 12'h040, 8'h08);
        irq_req <= 3'h1;
        wait_ctl(0);
        // A request already pending at halt must not wake
        irq_req <= 3'h2;
        apb(1, 12'h040, 8'h08);
        repeat (50) @(posedge pclk);
        chk(cpu_halted, 32'h0000_0001);
        port_a_in <= 8'hFE;
        wait_ctl(1);
        give_verdict();
    end
endmodule : watchdog_and_power_down_bench
